// >>> bridge_command_pkg.sv
// constants for the bridge command register block
// assumes a 12-bit APB byte address and 32-bit data
package bridge_command_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // register byte addresses
   localparam logic [ADDR_W-1:0] BRIDGE_COMMAND_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] BRIDGE_STATUS_OFS = 12'h008;
   localparam logic [ADDR_W-1:0] DEVICE_CONTROL_OFS = 12'h00C;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h010;
   localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 12'h014;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 12'h018;
   // bridge_command fields
   localparam int INT_DISABLE_BIT = 10;
   localparam int FAST_CONSECUTIVE_ENABLE_BIT = 9;
   localparam int SYSTEM_ERROR_MSG_ENABLE_BIT = 8;
   localparam int PARITY_ERROR_REPORT_ENABLE_BIT = 6;
   localparam int PALETTE_SNOOP_BIT = 5;
   localparam int WRITE_INVALIDATE_ENABLE_BIT = 4;
   localparam int SPECIAL_CYCLE_ENABLE_BIT = 3;
   localparam logic [15:0] BRIDGE_COMMAND_RESET = 16'h0000;
   // bridge_status fields
   localparam int MASTER_PARITY_ERR_BIT = 8;
   localparam int SIGNALED_SYS_ERR_BIT = 14;
   localparam logic [15:0] BRIDGE_STATUS_RESET = 16'h0000;
   // device control error-reporting enables
   localparam int NONFATAL_REPORT_BIT = 1;
   localparam int FATAL_REPORT_BIT = 2;
   localparam logic [15:0] DEVICE_CONTROL_RESET = 16'h0000;
   // interrupt event bits
   localparam int IRQ_NUM = 4;
   localparam int IRQ_SERR_SENT = 0;
   localparam int IRQ_PARITY_FLAG = 1;
   localparam int IRQ_INTX_ASSERT = 2;
   localparam int IRQ_INTX_DEASSERT = 3;
   localparam logic [IRQ_NUM-1:0] IRQ_RESET = 4'h0;
endpackage

// >>> bridge_command_props.sv
// assertions on the bridge command register ports
// assumes binding into bridge_command_register on one clock
`timescale 1ns/1ps
module bridge_command_props (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // messages and forwarding
   input wire logic intx_assert_msg_o,
   input wire logic intx_deassert_msg_o,
   input wire logic up_msi_i,
   input wire logic [3:0] up_intx_assert_i,
   input wire logic [3:0] up_intx_deassert_i,
   input wire logic up_msi_o,
   input wire logic [3:0] up_intx_assert_o,
   input wire logic [3:0] up_intx_deassert_o,
   input wire logic pri_fatal_err_i,
   input wire logic serr_msg_o,
   // control copies
   input wire logic int_disable_o,
   input wire logic system_error_msg_enable_o,
   input wire logic parity_error_report_enable_o
);
   logic active_q;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // own legacy interrupt seen as asserted
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i)
         active_q <= 1'b0;
      else if (intx_assert_msg_o)
         active_q <= 1'b1;
      else if (intx_deassert_msg_o)
         active_q <= 1'b0;
   end
   AST_READY_PULSE: assert property (pready_o |=> !pready_o)
      else $error("pready high two cycles");
   AST_READY_ACCESS: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
      else $error("pready outside access wait");
   AST_ERR_READY: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   AST_FWD_PASS: assert property (
      {up_msi_o, up_intx_assert_o, up_intx_deassert_o} == $past({up_msi_i, up_intx_assert_i, up_intx_deassert_i}))
      else $error("forwarded traffic altered");
   AST_NO_NEW_ASSERT: assert property (int_disable_o && $past(int_disable_o) |-> !intx_assert_msg_o)
      else $error("assert message while disabled");
   AST_DEASSERT_ON_DISABLE: assert property ($rose(int_disable_o) && active_q |-> ##[0:2] intx_deassert_msg_o)
      else $error("no deassert after disable");
   AST_PRI_SERR: assert property (pri_fatal_err_i ##1 system_error_msg_enable_o |-> serr_msg_o)
      else $error("primary error not reported");
   AST_PARITY_LOCK: assert property (parity_error_report_enable_o |=> parity_error_report_enable_o)
      else $error("parity enable changed after lock");
endmodule
bind bridge_command_register bridge_command_props props_u (.*);

// >>> bridge_command_register.sv
// command register of the virtual bridge with its message gating logic
// assumes event and error inputs come from logic on ref_clk_i, APB master on the same clock
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module bridge_command_register (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [bridge_command_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [bridge_command_pkg::DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [bridge_command_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // own interrupt sources, levels
   input wire logic pme_level_i,
   input wire logic hotplug_level_i,
   // own legacy interrupt messages, pulses
   output logic intx_assert_msg_o,
   output logic intx_deassert_msg_o,
   // forwarded upstream traffic
   input wire logic up_msi_i,
   input wire logic [3:0] up_intx_assert_i,
   input wire logic [3:0] up_intx_deassert_i,
   output logic up_msi_o,
   output logic [3:0] up_intx_assert_o,
   output logic [3:0] up_intx_deassert_o,
   // error detection, pulses
   input wire logic pri_fatal_err_i,
   input wire logic pri_nonfatal_err_i,
   input wire logic sec_fatal_err_i,
   input wire logic sec_nonfatal_err_i,
   input wire logic master_parity_err_i,
   // error message and control state
   output logic serr_msg_o,
   output logic int_disable_o,
   output logic system_error_msg_enable_o,
   output logic parity_error_report_enable_o,
   // interrupt
   output logic irq_o
);
   import bridge_command_pkg::*;

   logic [15:0] cmd_q;
   logic perr_locked_q;
   logic [15:0] status_q;
   logic [15:0] dctl_q;
   logic intx_active_q;
   logic [DATA_W-1:0] rdata_d;
   logic wr_fire;
   logic rd_take;
   logic wr_cmd;
   logic wr_sts;
   logic wr_dctl;
   logic serr_d;
   logic assert_d;
   logic deassert_d;
   logic own_level;
   logic parity_flag_set;
   logic [IRQ_NUM-1:0] irq_set;
   logic [IRQ_NUM-1:0] irq_clr;
   logic [IRQ_NUM-1:0] irq_status;
   logic [IRQ_NUM-1:0] irq_enable;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == BRIDGE_COMMAND_OFS) || (a == BRIDGE_STATUS_OFS) || (a == DEVICE_CONTROL_OFS) ||
                  (a == IRQ_STATUS_OFS) || (a == IRQ_CLEAR_OFS) || (a == IRQ_ENABLE_OFS);
   endfunction

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [DATA_W-1:0] wd,
                                           input logic [3:0] strb);
      merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
   endfunction

   // apb: one wait state, pready from a flop; writes land on the pready edge
   assign wr_fire = psel_i && penable_i && pready_o && pwrite_i && is_mapped(paddr_i);
   assign rd_take = psel_i && penable_i && !pready_o;
   assign wr_cmd = wr_fire && (paddr_i == BRIDGE_COMMAND_OFS);
   assign wr_sts = wr_fire && (paddr_i == BRIDGE_STATUS_OFS);
   assign wr_dctl = wr_fire && (paddr_i == DEVICE_CONTROL_OFS);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= rd_take;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= rd_take && !is_mapped(paddr_i);
      end
   end

   always_comb begin
      rdata_d = '0;
      unique case (paddr_i)
         BRIDGE_COMMAND_OFS: rdata_d[15:0] = cmd_q;
         BRIDGE_STATUS_OFS: rdata_d[15:0] = status_q;
         DEVICE_CONTROL_OFS: rdata_d[15:0] = dctl_q;
         IRQ_STATUS_OFS: rdata_d[IRQ_NUM-1:0] = irq_status;
         IRQ_ENABLE_OFS: rdata_d[IRQ_NUM-1:0] = irq_enable;
         default: rdata_d = '0;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= '0;
      end else if (rd_take) begin
         prdata_o <= pwrite_i ? '0 : rdata_d;
      end
   end

   // command register: only bits 10, 8 and 6 are storage
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_q <= BRIDGE_COMMAND_RESET;
      end else if (wr_cmd) begin
         if (pstrb_i[1]) begin
            cmd_q[INT_DISABLE_BIT] <= pwdata_i[INT_DISABLE_BIT];
            cmd_q[SYSTEM_ERROR_MSG_ENABLE_BIT] <= pwdata_i[SYSTEM_ERROR_MSG_ENABLE_BIT];
         end
         if (pstrb_i[0] && !perr_locked_q) begin
            cmd_q[PARITY_ERROR_REPORT_ENABLE_BIT] <= pwdata_i[PARITY_ERROR_REPORT_ENABLE_BIT];
         end
         cmd_q[FAST_CONSECUTIVE_ENABLE_BIT] <= 1'b0;
         cmd_q[PALETTE_SNOOP_BIT] <= 1'b0;
         cmd_q[WRITE_INVALIDATE_ENABLE_BIT] <= 1'b0;
         cmd_q[SPECIAL_CYCLE_ENABLE_BIT] <= 1'b0;
         cmd_q[15:11] <= 5'h00;
         cmd_q[7] <= 1'b0;
         cmd_q[2:0] <= 3'h0;
      end
   end

   // lock on first write touching lane 0
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         perr_locked_q <= 1'b0;
      end else if (wr_cmd && pstrb_i[0]) begin
         perr_locked_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dctl_q <= DEVICE_CONTROL_RESET;
      end else if (wr_dctl) begin
         dctl_q <= merge16(dctl_q, pwdata_i, pstrb_i) &
                   (16'h0001 << NONFATAL_REPORT_BIT | 16'h0001 << FATAL_REPORT_BIT);
      end
   end

   // error reporting
   always_comb begin
      serr_d = (pri_fatal_err_i && (cmd_q[SYSTEM_ERROR_MSG_ENABLE_BIT] || dctl_q[FATAL_REPORT_BIT])) ||
               (pri_nonfatal_err_i && (cmd_q[SYSTEM_ERROR_MSG_ENABLE_BIT] || dctl_q[NONFATAL_REPORT_BIT]));
      // secondary errors only by device control
      serr_d = serr_d || (sec_fatal_err_i && dctl_q[FATAL_REPORT_BIT]) ||
               (sec_nonfatal_err_i && dctl_q[NONFATAL_REPORT_BIT]);
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         serr_msg_o <= 1'b0;
      end else begin
         serr_msg_o <= serr_d;
      end
   end

   // flag cannot set while parity enable is clear
   assign parity_flag_set = master_parity_err_i && cmd_q[PARITY_ERROR_REPORT_ENABLE_BIT];

   // status: write one to clear, a new event wins over the clear
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_q <= BRIDGE_STATUS_RESET;
      end else begin
         if (wr_sts && pstrb_i[1] && pwdata_i[MASTER_PARITY_ERR_BIT]) begin
            status_q[MASTER_PARITY_ERR_BIT] <= 1'b0;
         end
         if (wr_sts && pstrb_i[1] && pwdata_i[SIGNALED_SYS_ERR_BIT]) begin
            status_q[SIGNALED_SYS_ERR_BIT] <= 1'b0;
         end
         if (parity_flag_set) begin
            status_q[MASTER_PARITY_ERR_BIT] <= 1'b1;
         end
         if (serr_d) begin
            status_q[SIGNALED_SYS_ERR_BIT] <= 1'b1;
         end
      end
   end

   // own legacy interrupt emulation
   assign own_level = pme_level_i || hotplug_level_i;

   always_comb begin
      assert_d = own_level && !intx_active_q && !cmd_q[INT_DISABLE_BIT];
      // de-assert when disabled or source gone
      deassert_d = intx_active_q && (cmd_q[INT_DISABLE_BIT] || !own_level);
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         intx_active_q <= 1'b0;
      end else if (assert_d) begin
         intx_active_q <= 1'b1;
      end else if (deassert_d) begin
         intx_active_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         intx_assert_msg_o <= 1'b0;
         intx_deassert_msg_o <= 1'b0;
      end else begin
         intx_assert_msg_o <= assert_d;
         intx_deassert_msg_o <= deassert_d;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         up_msi_o <= 1'b0;
         up_intx_assert_o <= 4'h0;
         up_intx_deassert_o <= 4'h0;
      end else begin
         up_msi_o <= up_msi_i;
         up_intx_assert_o <= up_intx_assert_i;
         up_intx_deassert_o <= up_intx_deassert_i;
      end
   end

   // control state seen by neighbouring logic
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_disable_o <= 1'b0;
         system_error_msg_enable_o <= 1'b0;
         parity_error_report_enable_o <= 1'b0;
      end else begin
         int_disable_o <= cmd_q[INT_DISABLE_BIT];
         system_error_msg_enable_o <= cmd_q[SYSTEM_ERROR_MSG_ENABLE_BIT];
         parity_error_report_enable_o <= cmd_q[PARITY_ERROR_REPORT_ENABLE_BIT];
      end
   end

   // block events into the interrupt bank
   always_comb begin
      irq_set = IRQ_RESET;
      irq_set[IRQ_SERR_SENT] = serr_d;
      irq_set[IRQ_PARITY_FLAG] = parity_flag_set;
      irq_set[IRQ_INTX_ASSERT] = assert_d;
      irq_set[IRQ_INTX_DEASSERT] = deassert_d;
      irq_clr = (wr_fire && (paddr_i == IRQ_CLEAR_OFS) && pstrb_i[0]) ? pwdata_i[IRQ_NUM-1:0] : IRQ_RESET;
   end

   irq_bank #(
      .N(IRQ_NUM)
   ) u_irq (
      .clk_i(ref_clk_i),
      .rst_i(rst_i),
      .set_i(irq_set),
      .clr_i(irq_clr),
      .en_wr_i(wr_fire && (paddr_i == IRQ_ENABLE_OFS) && pstrb_i[0]),
      .en_data_i(pwdata_i[IRQ_NUM-1:0]),
      .status_o(irq_status),
      .enable_o(irq_enable),
      .irq_o(irq_o)
   );
endmodule

// >>> irq_bank.sv
// sticky event status with enable mask and one level interrupt
// assumes set and clear pulses come from logic on the same clock
`timescale 1ns/1ps
module irq_bank #(
   parameter int N = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // events and software access
   input wire logic [N-1:0] set_i,
   input wire logic [N-1:0] clr_i,
   input wire logic en_wr_i,
   input wire logic [N-1:0] en_data_i,
   // state
   output logic [N-1:0] status_o,
   output logic [N-1:0] enable_o,
   output logic irq_o
);
   logic [N-1:0] status_d;

   // set wins over a clear in the same cycle
   always_comb begin
      status_d = (status_o & ~clr_i) | set_i;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_o <= '0;
      end else begin
         status_o <= status_d;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_o <= '0;
      end else if (en_wr_i) begin
         enable_o <= en_data_i;
      end
   end

   // irq follows the next status so it stays in step with the sticky bits
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_d & (en_wr_i ? en_data_i : enable_o));
      end
   end
endmodule

// >>> tb.sv
// self-checking bench for the bridge command register
// assumes the design answers apb with one wait state
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   import bridge_command_pkg::*;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [ADDR_W-1:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, r, d;
   logic [3:0] pstrb_i = 4'hF, up_intx_assert_i = 4'h0, up_intx_deassert_i = 4'h0;
   logic [3:0] up_intx_assert_o, up_intx_deassert_o;
   logic pready_o, pslverr_o, e, up_msi_i = 1'b0, up_msi_o, pme_level_i = 1'b0, hotplug_level_i = 1'b0;
   logic pri_fatal_err_i = 1'b0, pri_nonfatal_err_i = 1'b0, sec_fatal_err_i = 1'b0;
   logic sec_nonfatal_err_i = 1'b0, master_parity_err_i = 1'b0;
   logic intx_assert_msg_o, intx_deassert_msg_o, serr_msg_o, irq_o;
   logic int_disable_o, system_error_msg_enable_o, parity_error_report_enable_o;
   logic [8:0] fwd_q = 9'h000;
   logic [ADDR_W-1:0] ofs [5] = '{BRIDGE_COMMAND_OFS, BRIDGE_STATUS_OFS, DEVICE_CONTROL_OFS,
      IRQ_STATUS_OFS, IRQ_ENABLE_OFS};
   int n_mismatch = 0, n_checks = 0, n_as = 0, n_de = 0, n_serr = 0, seed = 32'h68ae;
   bridge_command_register dut_u (.*);
   always #5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) fwd_q <= {up_msi_i, up_intx_assert_i, up_intx_deassert_i};
   always @(negedge ref_clk_i) begin
      n_as += (intx_assert_msg_o === 1'b1);
      n_de += (intx_deassert_msg_o === 1'b1);
      n_serr += (serr_msg_o === 1'b1);
      if (!rst_i)
         `CHK({up_msi_o, up_intx_assert_o, up_intx_deassert_o}, fwd_q)
   end
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // waits are bounded so a dead slave ends the run
   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      int i;
      begin
         @(posedge ref_clk_i);
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= wd;
         @(posedge ref_clk_i);
         penable_i <= 1'b1;
         i = 0;
         // ready, data and error are taken at the rising edge only
         @(posedge ref_clk_i);
         while (pready_o !== 1'b1 && i < 20) begin
            @(posedge ref_clk_i);
            i++;
         end
         if (i == 20) begin
            n_mismatch++;
            print_verdict;
         end
         r = prdata_o;
         e = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
      begin
         apb(1'b0, a, 32'h0);
         `CHK(r, x)
      end
   endtask
   task ev(input int k);
      begin
         @(posedge ref_clk_i);
         case (k)
            0: pri_fatal_err_i <= 1'b1;
            1: pri_nonfatal_err_i <= 1'b1;
            2: sec_fatal_err_i <= 1'b1;
            4: sec_nonfatal_err_i <= 1'b1;
            default: master_parity_err_i <= 1'b1;
         endcase
         @(posedge ref_clk_i);
         {pri_fatal_err_i, pri_nonfatal_err_i, sec_fatal_err_i, master_parity_err_i} <= 4'h0;
         sec_nonfatal_err_i <= 1'b0;
         repeat (2) @(negedge ref_clk_i);
      end
   endtask
   initial begin
      #100000;
      n_mismatch++;
      print_verdict;
   end
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (ofs[i]) rd(ofs[i], 32'h0);
      rd(12'h020, 32'h0);
      `CHK(e, 1'b1)
      ev(3);
      rd(BRIDGE_STATUS_OFS, 32'h0);
      $display("test reset done");
      apb(1'b1, IRQ_ENABLE_OFS, 32'hF);
      d = $random(seed) | 32'h0000FFFF;
      apb(1'b1, BRIDGE_COMMAND_OFS, d);
      rd(BRIDGE_COMMAND_OFS, 32'h0540);
      `CHK({int_disable_o, system_error_msg_enable_o, parity_error_report_enable_o}, 3'h7)
      d = $random(seed);
      apb(1'b1, BRIDGE_COMMAND_OFS, d);
      rd(BRIDGE_COMMAND_OFS, (d & 32'h0500) | 32'h0040);
      ev(3);
      rd(BRIDGE_STATUS_OFS, 32'h0100);
      apb(1'b1, BRIDGE_STATUS_OFS, 32'h0100);
      $display("test command bits done");
      apb(1'b1, BRIDGE_COMMAND_OFS, 32'h0100);
      ev(2);
      `CHK(n_serr, 0)
      ev(0);
      `CHK(n_serr, 1)
      rd(BRIDGE_STATUS_OFS, 32'h4000);
      apb(1'b1, BRIDGE_COMMAND_OFS, 32'h0);
      apb(1'b1, DEVICE_CONTROL_OFS, 32'h4);
      ev(1);
      `CHK(n_serr, 1)
      ev(2);
      `CHK(n_serr, 2)
      ev(4);
      `CHK(n_serr, 2)
      rd(IRQ_STATUS_OFS, 32'h3);
      `CHK(irq_o, 1'b1)
      apb(1'b1, IRQ_CLEAR_OFS, 32'hF);
      @(negedge ref_clk_i);
      `CHK(irq_o, 1'b0)
      $display("test errors done");
      pme_level_i <= 1'b1;
      repeat (4) @(negedge ref_clk_i);
      `CHK(n_as, 1)
      apb(1'b1, BRIDGE_COMMAND_OFS, 32'h0400);
      repeat (4) @(negedge ref_clk_i);
      `CHK(n_de, 1)
      `CHK(n_as, 1)
      rd(IRQ_STATUS_OFS, 32'hC);
      apb(1'b1, IRQ_ENABLE_OFS, 32'h0);
      @(negedge ref_clk_i);
      `CHK(irq_o, 1'b0)
      $display("test legacy interrupt done");
      repeat (40) begin
         @(posedge ref_clk_i);
         up_msi_i <= $random(seed);
         up_intx_assert_i <= $random(seed);
         up_intx_deassert_i <= $random(seed);
      end
      @(posedge ref_clk_i);
      {up_msi_i, up_intx_assert_i, up_intx_deassert_i} <= 9'h000;
      repeat (2) @(negedge ref_clk_i);
      $display("test forwarding done");
      print_verdict;
   end
endmodule
